// ---- design/io_lamp_pkg.sv ----
/*
 * Package for the on-board I/O indicator logic: register map, field
 * layouts, reset values, flash timing and the carrier structs.
 * Assumes one 25 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package io_lamp_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int ANA_CH_N = 5;          // Analog channels
    localparam int DIG_CH_N = 16;         // Digital channels
    localparam int GRP_N    = 2;          // Supply groups

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 25_000_000;  // System clock rate
    localparam int FLASH_HALF_MS = 250;         // Half flash period, ms
    localparam int FLASH_HALF_CYC =
        (CLK_HZ / 1000) * FLASH_HALF_MS;        // Cycles per half period
    localparam int FLASH_CW = 24;               // Flash counter width

    // ------------------------------------------------------------
    // Register word indices (word index in byte address bits 3:2)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_W   = 4'h4;     // Address width (bits)
    localparam logic [2:0] REG_CTRL = 3'h0;     // Section control
    localparam logic [2:0] REG_STAT = 3'h1;     // Lamp state, read only
    localparam logic [2:0] REG_IRQ  = 3'h2;     // Sticky events, W1C
    localparam logic [2:0] REG_MASK = 3'h3;     // Event mask

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_ANA_PARAM = 0;   // Valid parameters received
    localparam int CTRL_DIG_READY = 1;   // Digital section ready
    localparam int CTRL_CAL_DONE  = 2;   // Calibration check finished
    localparam int CTRL_CAL_BAD   = 3;   // Calibration invalid/missing
    localparam int EVT_ANA_ERR    = 0;   // Analog error appeared
    localparam int EVT_DIG_DIAG   = 1;   // Digital diagnosis appeared
    localparam int EVT_SUPPLY     = 2;   // A supply group dropped
    localparam int EVT_N          = 3;   // Number of events

    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [31:0] BAD_DATA = 32'hdead_0bad; // Unmapped read

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic run;      // Run lamp
        logic err;      // Error lamp
    } sect_lamp_type;

    typedef struct packed {
        logic [ANA_CH_N-1:0] enabled;   // Channel parameterised
        logic [ANA_CH_N-1:0] fault;     // Channel error, alarm pending
    } ana_chan_type;

    typedef struct packed {
        logic [ANA_CH_N-1:0] ok;        // Normal colour lamp
        logic [ANA_CH_N-1:0] fault;     // Fault colour lamp
    } ana_lamp_type;

endpackage : io_lamp_pkg

// ---- design/io_lamp.sv ----
/*
 * On-board I/O status and error indicator logic with an Avalon-MM slave
 * for section control, lamp readback and event interrupts.
 * Assumes status inputs from other clock domains or pins; each is passed
 * through two flip-flops before use. Digital levels arrive already
 * through their own input delay filter.
 */
// What this block does
// RULE_01: Analog startup: run flashes, error off
// RULE_02: Analog parameterised, no error: run steady
// RULE_03: Analog channel error: run on, error flashes
// RULE_04: Analog channel lamp off when disabled
// RULE_05: Faulted analog channel lamp shows fault
// RULE_06: Bad calibration lights maintenance lamp
// RULE_07: Digital startup: run flashes, error off
// RULE_08: Digital ready: run steady, error off
// RULE_09: Digital diagnosis pending: error flashes
// RULE_10: Group lamp lit while supply adequate
// RULE_11: Digital channel lamp mirrors signal level
// RULE_12: Use digital input filter, not counter filter
// RULE_13: One shared free-running flash divider
module io_lamp #(
    // Flash half period in clock cycles; a bench may shorten it
    parameter int FLASH_HALF = io_lamp_pkg::FLASH_HALF_CYC
) (
    // Clock and reset
    input  wire logic                        CLK_SYS_I,
    input  wire logic                        ARST_N_I,
    // Avalon-MM slave
    input  wire logic [io_lamp_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
    input  wire logic                        AVS_READ_I,
    input  wire logic                        AVS_WRITE_I,
    input  wire logic [31:0]                 AVS_WRITEDATA_I,
    input  wire logic [3:0]                  AVS_BYTEENABLE_I,
    output logic      [31:0]                 AVS_READDATA_O,
    output logic                             AVS_WAITREQUEST_O,
    output logic      [1:0]                  AVS_RESPONSE_O,
    // Module status inputs
    input  wire io_lamp_pkg::ana_chan_type   ANA_CHAN_I,
    input  wire logic                        DIG_DIAG_I,
    input  wire logic [io_lamp_pkg::GRP_N-1:0]    SUPPLY_OK_I,
    input  wire logic [io_lamp_pkg::DIG_CH_N-1:0] DIG_LEVEL_I,
    // Lamp drives
    output io_lamp_pkg::sect_lamp_type       ANA_LAMP_O,
    output io_lamp_pkg::sect_lamp_type       DIG_LAMP_O,
    output io_lamp_pkg::ana_lamp_type        CHANNEL_INDICATOR_O,
    output logic                             MAINTENANCE_INDICATOR_O,
    output logic [io_lamp_pkg::GRP_N-1:0]    SUPPLY_GROUP_INDICATOR_O,
    output logic [io_lamp_pkg::DIG_CH_N-1:0] DIG_CHANNEL_INDICATOR_O,
    // Interrupt
    output logic                             IRQ_O
);
    import io_lamp_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int SYNC_W = 2*ANA_CH_N + 1 + GRP_N + DIG_CH_N;

    logic [SYNC_W-1:0] meta_q;     // First stage, read by sync_q only
    logic [SYNC_W-1:0] sync_q;     // Second stage, safe to use
    ana_chan_type      ana_s;      // Synchronised analog status
    logic              dig_diag_s; // Synchronised digital diagnosis
    logic [GRP_N-1:0]  supply_s;   // Synchronised supply detection
    logic [DIG_CH_N-1:0] level_s;  // Synchronised filtered levels

    // Two flops on every external status line
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {ANA_CHAN_I, DIG_DIAG_I, SUPPLY_OK_I, DIG_LEVEL_I};
            sync_q <= meta_q;
        end
    end

    assign {ana_s, dig_diag_s, supply_s, level_s} = sync_q;

    // ------------------------------------------------------------
    // Flash divider
    // ------------------------------------------------------------
    logic [FLASH_CW-1:0] flash_cnt_q;  // Half period counter
    logic                flash_q;      // Common flash phase

    // RULE_13 shared divider
    // Free-running so all flashing lamps stay in phase
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            flash_cnt_q <= '0;
            flash_q     <= 1'b0;
        end else if (flash_cnt_q == FLASH_CW'(FLASH_HALF - 1)) begin
            flash_cnt_q <= '0;
            flash_q     <= ~flash_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [31:0]      ctrl_q;   // Section control bits
    logic [EVT_N-1:0] evt_q;    // Sticky events
    logic [EVT_N-1:0] mask_q;   // Event enables
    logic [2:0]       widx;     // Word index
    logic             wr_hit;   // Accepted write
    logic             legal;    // Address maps a register
    logic [31:0]      mask_wd;  // Mask word after lane merge

    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Only two address bits select a word; top index bit stays clear
    assign widx   = {1'b0, AVS_ADDRESS_I[ADDR_W-1:2]};
    assign legal  = (widx <= REG_MASK);
    assign wr_hit = AVS_WRITE_I && !AVS_WAITREQUEST_O;

    // Control register; software reports section progress here
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_hit && widx == REG_CTRL) begin
            ctrl_q <= be_merge(ctrl_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        end
    end

    // Mask register
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            mask_q <= MASK_RST[EVT_N-1:0];
        end else if (wr_hit && widx == REG_MASK) begin
            mask_q <= mask_wd[EVT_N-1:0];
        end
    end

    // Merge kept apart; a call result cannot be part-selected
    assign mask_wd = be_merge({29'h0, mask_q}, AVS_WRITEDATA_I,
                              AVS_BYTEENABLE_I);

    // ------------------------------------------------------------
    // Section state
    // ------------------------------------------------------------
    logic ana_param;    // Analog parameters valid
    logic ana_err;      // Any enabled analog channel faulted
    logic dig_ready;    // Digital section ready
    logic dig_err;      // Digital diagnosis pending
    logic ana_err_q;    // Delayed for edge detect
    logic dig_err_q;    // Delayed for edge detect
    logic [GRP_N-1:0] supply_q;    // Delayed for edge detect
    logic [EVT_N-1:0] evt_set;     // Event pulses

    assign ana_param = ctrl_q[CTRL_ANA_PARAM];
    assign dig_ready = ctrl_q[CTRL_DIG_READY];
    assign ana_err   = ana_param && |(ana_s.enabled & ana_s.fault);
    assign dig_err   = dig_ready && dig_diag_s;

    assign evt_set[EVT_ANA_ERR]  = ana_err && !ana_err_q;
    assign evt_set[EVT_DIG_DIAG] = dig_err && !dig_err_q;
    assign evt_set[EVT_SUPPLY]   = |(supply_q & ~supply_s);

    // Edge history for event pulses
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ana_err_q <= 1'b0;
            dig_err_q <= 1'b0;
            supply_q  <= '0;
        end else begin
            ana_err_q <= ana_err;
            dig_err_q <= dig_err;
            supply_q  <= supply_s;
        end
    end

    // Sticky events; a new event wins over a write-one clear
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            evt_q <= '0;
        end else if (wr_hit && widx == REG_IRQ && AVS_BYTEENABLE_I[0]) begin
            evt_q <= (evt_q & ~AVS_WRITEDATA_I[EVT_N-1:0]) | evt_set;
        end else begin
            evt_q <= evt_q | evt_set;
        end
    end

    // ------------------------------------------------------------
    // Lamp drives, all registered
    // ------------------------------------------------------------
    // Section lamps
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ANA_LAMP_O <= '0;
            DIG_LAMP_O <= '0;
        end else begin
            // RULE_01 RULE_02 analog run
            ANA_LAMP_O.run <= ana_param ? 1'b1 : flash_q;
            // RULE_03 analog error flash
            ANA_LAMP_O.err <= ana_err && flash_q;
            // RULE_07 RULE_08 digital run
            DIG_LAMP_O.run <= dig_ready ? 1'b1 : flash_q;
            // RULE_09 digital error flash
            DIG_LAMP_O.err <= dig_err && flash_q;
        end
    end

    // Channel, supply and maintenance lamps
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            CHANNEL_INDICATOR_O      <= '0;
            MAINTENANCE_INDICATOR_O  <= 1'b0;
            SUPPLY_GROUP_INDICATOR_O <= '0;
            DIG_CHANNEL_INDICATOR_O  <= '0;
        end else begin
            // RULE_04 channel normal lamp
            CHANNEL_INDICATOR_O.ok <= ana_param ?
                (ana_s.enabled & ~ana_s.fault) : '0;
            // RULE_05 channel fault lamp
            CHANNEL_INDICATOR_O.fault <= ana_param ?
                (ana_s.enabled & ana_s.fault) : '0;
            // RULE_06 calibration check result
            MAINTENANCE_INDICATOR_O <= ctrl_q[CTRL_CAL_DONE] &&
                                       ctrl_q[CTRL_CAL_BAD];
            // RULE_10 supply group lamps
            SUPPLY_GROUP_INDICATOR_O <= supply_s;
            // RULE_11 RULE_12 filtered level mirror
            DIG_CHANNEL_INDICATOR_O <= level_s;
        end
    end

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    logic [31:0] status_word;   // Live lamp state for readback

    assign status_word = {
        {(32-7-GRP_N){1'b0}}, SUPPLY_GROUP_INDICATOR_O,
        MAINTENANCE_INDICATOR_O, flash_q,
        DIG_LAMP_O.err, DIG_LAMP_O.run,
        ANA_LAMP_O.err, ANA_LAMP_O.run, ana_err};

    // Zero wait states; every request is taken at once
    assign AVS_WAITREQUEST_O = 1'b0;
    assign AVS_RESPONSE_O    = legal ? 2'h0 : 2'h2;

    // Read mux, combinational so data stands at the accepting edge
    always_comb begin
        unique case (widx)
            REG_CTRL: AVS_READDATA_O = ctrl_q;
            REG_STAT: AVS_READDATA_O = status_word;
            REG_IRQ:  AVS_READDATA_O = {29'h0, evt_q};
            REG_MASK: AVS_READDATA_O = {29'h0, mask_q};
            default:  AVS_READDATA_O = BAD_DATA;
        endcase
    end

    assign IRQ_O = |(evt_q & mask_q);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!ARST_N_I);

    sequence s_flash_toggles;
        $changed(flash_q);
    endsequence

    property p_flash_period;
        s_flash_toggles |=> !$changed(flash_q) [*8];
    endproperty
    a_flash_period: assert property (p_flash_period) // RULE_13
        else $error("flash toggled too soon");

    property p_ana_start;
        !ana_param |=> !ANA_LAMP_O.err && ANA_LAMP_O.run == $past(flash_q);
    endproperty
    a_ana_start: assert property (p_ana_start) // RULE_01
        else $error("analog startup lamps wrong");

    property p_ana_run;
        ana_param |=> ANA_LAMP_O.run;
    endproperty
    a_ana_run: assert property (p_ana_run) // RULE_02
        else $error("analog run lamp not steady");

    property p_ana_err;
        ana_err |=> ANA_LAMP_O.err == $past(flash_q) && ANA_LAMP_O.run;
    endproperty
    a_ana_err: assert property (p_ana_err) // RULE_03
        else $error("analog error lamp not flashing");

    property p_chan_off;
        !ana_s.enabled[0] |=> !CHANNEL_INDICATOR_O.ok[0]
                            && !CHANNEL_INDICATOR_O.fault[0];
    endproperty
    a_chan_off: assert property (p_chan_off) // RULE_04
        else $error("disabled channel lamp lit");

    property p_chan_fault;
        ana_param && ana_s.enabled[0] && ana_s.fault[0]
            |=> CHANNEL_INDICATOR_O.fault[0];
    endproperty
    a_chan_fault: assert property (p_chan_fault) // RULE_05
        else $error("fault lamp missing");

    property p_maintenance_indicator;
        ctrl_q[CTRL_CAL_DONE] && ctrl_q[CTRL_CAL_BAD]
            |=> MAINTENANCE_INDICATOR_O;
    endproperty
    a_maintenance_indicator: assert property (p_maintenance_indicator) // RULE_06
        else $error("maintenance lamp not lit");

    property p_dig_lamps;
        dig_ready && !dig_err |=> DIG_LAMP_O.run && !DIG_LAMP_O.err;
    endproperty
    a_dig_lamps: assert property (p_dig_lamps) // RULE_08
        else $error("digital ready lamps wrong");

    property p_dig_diag;
        (DIG_DIAG_I && dig_ready) [*4] |-> DIG_LAMP_O.err == $past(flash_q);
    endproperty
    a_dig_diag: assert property (p_dig_diag) // RULE_09
        else $error("digital error lamp not flashing");

    property p_supply;
        SUPPLY_OK_I[0] [*4] |-> SUPPLY_GROUP_INDICATOR_O[0];
    endproperty
    a_supply: assert property (p_supply) // RULE_10
        else $error("supply lamp not lit");

    property p_level;
        DIG_LEVEL_I[0] |-> ##3 DIG_CHANNEL_INDICATOR_O[0];
    endproperty
    a_level: assert property (p_level) // RULE_11
        else $error("channel lamp not following level");

endmodule // io_lamp

// ---- tb/tb_top.sv ----
/*
 * Self-checking bench for the on-board I/O indicator logic.
 * Assumes the register map, field positions and reset values of
 * io_lamp_pkg, a zero-wait Avalon-MM slave and 3-edge lamp latency.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import io_lamp_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                clk;          // System clock
    logic                arst_n;       // Async reset, active low
    logic [3:0]          address;      // Bus byte address
    logic                read;         // Read strobe
    logic                write;        // Write strobe
    logic [31:0]         writedata;    // Write data
    logic [3:0]          byteenable;   // Lane enables
    logic [31:0]         readdata;     // Read data
    logic                waitreq;      // Slave stall
    logic [1:0]          response;     // Response code
    ana_chan_type        ana_chan;     // Analog channel status
    logic                dig_diag;     // Digital diagnosis
    logic [GRP_N-1:0]    supply_ok;    // Supply per group
    logic [DIG_CH_N-1:0] dig_level;    // Filtered levels
    sect_lamp_type       ana_lamp;     // Analog section lamps
    sect_lamp_type       dig_lamp;     // Digital section lamps
    ana_lamp_type        chan_lamp;    // Analog channel lamps
    logic                maintenance_indicator;        // Maintenance lamp
    logic [GRP_N-1:0]    grp_lamp;     // Supply group lamps
    logic [DIG_CH_N-1:0] dig_lamp_ch;  // Digital channel lamps
    logic                irq;          // Interrupt line
    logic [31:0]         d;            // Scratch read value
    logic [7:0]          seen;         // Lamp levels seen in a watch
    int                  apart;        // Cycles run lamps differ

    // Short flash half period so flashing shows within the run
    localparam int FLASH_TB = 16;
    int                  errors;       // Mismatches
    int                  comparisons;  // Checks made

    io_lamp #(
        .FLASH_HALF              (FLASH_TB)
    ) u_io_lamp (
        .CLK_SYS_I               (clk),
        .ARST_N_I                (arst_n),
        .AVS_ADDRESS_I           (address),
        .AVS_READ_I              (read),
        .AVS_WRITE_I             (write),
        .AVS_WRITEDATA_I         (writedata),
        .AVS_BYTEENABLE_I        (byteenable),
        .AVS_READDATA_O          (readdata),
        .AVS_WAITREQUEST_O       (waitreq),
        .AVS_RESPONSE_O          (response),
        .ANA_CHAN_I              (ana_chan),
        .DIG_DIAG_I              (dig_diag),
        .SUPPLY_OK_I             (supply_ok),
        .DIG_LEVEL_I             (dig_level),
        .ANA_LAMP_O              (ana_lamp),
        .DIG_LAMP_O              (dig_lamp),
        .CHANNEL_INDICATOR_O     (chan_lamp),
        .MAINTENANCE_INDICATOR_O (maintenance_indicator),
        .SUPPLY_GROUP_INDICATOR_O(grp_lamp),
        .DIG_CHANNEL_INDICATOR_O (dig_lamp_ch),
        .IRQ_O                   (irq)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Word index to byte address
    function automatic logic [3:0] adr(input logic [2:0] r);
        return {r[1:0], 2'b00};
    endfunction

    // Compare and count
    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask

    // One bus cycle; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] wd, input logic [3:0] be,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        address    <= a;
        writedata  <= wd;
        byteenable <= be;
        read       <= !wr;
        write      <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 100);
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wreg(input logic [2:0] r, input logic [31:0] v);
        logic [31:0] x;
        bus(1'b1, adr(r), v, 4'hf, x);
    endtask

    task automatic rreg(input logic [2:0] r, output logic [31:0] v);
        bus(1'b0, adr(r), 32'h0, 4'hf, v);
    endtask

    // Wait out the 3-edge input-to-lamp path, sample off the edge
    task automatic settle;
        repeat (4) @(posedge clk);
        #1;
    endtask

    // Two flash periods; per section lamp {seen high, seen low}
    task automatic watch;
        logic [3:0] l;
        seen  = '0;
        apart = 0;
        repeat (4 * FLASH_TB) begin
            @(posedge clk);
            l = {ana_lamp, dig_lamp};
            for (int k = 0; k < 4; k++) begin
                seen[2*k+1] = seen[2*k+1] | l[k];
                seen[2*k]   = seen[2*k] | !l[k];
            end
            apart = apart + int'(ana_lamp.run != dig_lamp.run);
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rreg(REG_CTRL, d);
        check("ctrl reset", CTRL_RST, d);
        rreg(REG_MASK, d);
        check("mask reset", MASK_RST, d);
        check("response", 32'h0, 32'(response));
        // Lanes off: write must not land
        bus(1'b1, adr(REG_CTRL), 32'hf, 4'h0, d);
        rreg(REG_CTRL, d);
        check("ctrl no lanes", CTRL_RST, d);
        check("irq idle", 32'h0, 32'(irq));
        $display("test regs done");
    endtask

    // Startup lamps watched over two flash periods; run lamps checked in phase
    task automatic t_startup;
        watch;
        check("ana run", 32'h3, 32'(seen[7:6]));
        check("ana err", 32'h1, 32'(seen[5:4]));
        check("dig run", 32'h3, 32'(seen[3:2]));
        check("dig err", 32'h1, 32'(seen[1:0]));
        check("in phase", 32'h0, 32'(apart));
        check("maintenance_indicator", 32'h0, 32'(maintenance_indicator));
        $display("test startup done");
    endtask

    task automatic t_analog;
        wreg(REG_CTRL, 32'h1);
        settle;
        check("ana lamp", 32'h2, 32'(ana_lamp));
        check("chan ok", 32'h1f, 32'(chan_lamp.ok));
        @(posedge clk);
        ana_chan.enabled <= 5'h1e;
        settle;
        check("chan off", 32'h1e, 32'(chan_lamp.ok));
        @(posedge clk);
        ana_chan.fault <= 5'h04;
        settle;
        watch;
        check("ana run", 32'h2, 32'(seen[7:6]));
        check("ana err", 32'h3, 32'(seen[5:4]));
        rreg(REG_STAT, d);
        check("stat ana_err", 32'h1, 32'(d[0]));
        check("chan fault", 32'h04, 32'(chan_lamp.fault));
        check("chan ok", 32'h1a, 32'(chan_lamp.ok));
        rreg(REG_IRQ, d);
        check("ana event", 32'h1, 32'(d[EVT_ANA_ERR]));
        check("irq masked", 32'h0, 32'(irq));
        wreg(REG_MASK, 32'h1);
        #1;
        check("irq on", 32'h1, 32'(irq));
        wreg(REG_IRQ, 32'h1);
        #1;
        check("irq cleared", 32'h0, 32'(irq));
        wreg(REG_MASK, 32'h0);
        @(posedge clk);
        ana_chan.fault <= 5'h00;
        $display("test analog done");
    endtask

    task automatic t_digital;
        wreg(REG_CTRL, 32'h3);
        settle;
        check("dig lamp", 32'h2, 32'(dig_lamp));
        @(posedge clk);
        dig_diag <= 1'b1;
        settle;
        watch;
        check("dig run", 32'h2, 32'(seen[3:2]));
        check("dig err", 32'h3, 32'(seen[1:0]));
        rreg(REG_STAT, d);
        check("stat dig run", 32'h1, 32'(d[3]));
        rreg(REG_IRQ, d);
        check("dig event", 32'h1, 32'(d[EVT_DIG_DIAG]));
        wreg(REG_IRQ, 32'h2);
        @(posedge clk);
        dig_diag <= 1'b0;
        settle;
        check("dig back", 32'h2, 32'(dig_lamp));
        $display("test digital done");
    endtask

    task automatic t_supply;
        logic [GRP_N-1:0] pat [4] = '{2'b01, 2'b10, 2'b11, 2'b00};
        foreach (pat[i]) begin
            @(posedge clk);
            supply_ok <= pat[i];
            settle;
            check("group lamp", 32'(pat[i]), 32'(grp_lamp));
        end
        rreg(REG_IRQ, d);
        check("drop event", 32'h1, 32'(d[EVT_SUPPLY]));
        wreg(REG_MASK, 32'h4);
        #1;
        check("irq drop", 32'h1, 32'(irq));
        wreg(REG_IRQ, 32'h4);
        #1;
        check("irq cleared", 32'h0, 32'(irq));
        $display("test supply done");
    endtask

    task automatic t_levels;
        logic [15:0] pat [4] = '{16'h0000, 16'hffff, 16'ha5c3, 16'h0001};
        foreach (pat[i]) begin
            @(posedge clk);
            dig_level <= pat[i];
            settle;
            check("dig chan", 32'(pat[i]), 32'(dig_lamp_ch));
        end
        $display("test levels done");
    endtask

    task automatic t_calib;
        logic [31:0] cw [3] = '{32'h7, 32'hf, 32'hb};
        logic        ex [3] = '{1'b0, 1'b1, 1'b0};
        foreach (cw[i]) begin
            wreg(REG_CTRL, cw[i]);
            settle;
            check("maintenance_indicator", 32'(ex[i]), 32'(maintenance_indicator));
        end
        $display("test calib done");
    endtask

    // ------------------------------------------------------------
    // Verdict
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Watchdog; tests need well under 2,000 cycles
    initial begin
        #(40 * 20000);
        errors++;
        complete_run;
    end

    // Main sequence
    initial begin
        errors      = 0;
        comparisons = 0;
        arst_n      = 1'b0;
        address     = 4'h0;
        read        = 1'b0;
        write       = 1'b0;
        writedata   = 32'h0;
        byteenable  = 4'hf;
        ana_chan    = '{enabled: 5'h1f, fault: 5'h00};
        dig_diag    = 1'b0;
        supply_ok   = 2'b00;
        dig_level   = 16'h0000;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        t_regs;
        t_startup;
        t_analog;
        t_digital;
        t_supply;
        t_levels;
        t_calib;
        complete_run;
    end

endmodule // tb_top
